// ===== design/periodic_tick_timer.sv
// periodic tick timer: 8-bit counter, run/clear, four tick flags, irq
// assumes apb master on I_CLK, synchronous active-high reset
//
// Our own choice: the APB slave port.
`timescale 1ns/10ps

// Summary of operation
// - count only while running; clear resets counter
// - counter readable, writes ignored
// - four enables at bits 3..0, reset zero
// - events set flags; write one clears
module periodic_tick_timer
  import tick_timer_pkg::*;
#(
  parameter int P_STEP_CYCLES = STEP_CYCLES
) (
  input  wire logic        I_CLK,
  input  wire logic        I_RST,
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [31:0] I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  output logic      [31:0] O_PRDATA,
  output logic             O_IRQ
);

  ////////////////////////////////////////////////////////////////////
  // registers, their next values and bus decode
  logic            run_q;
  logic            run_d;
  logic [7:0]      count_q;
  logic [7:0]      count_d;
  logic [31:0]     pre_q;
  logic [31:0]     pre_d;
  logic            pre_last;
  logic            step;
  tick_events_type mask_q;
  tick_events_type mask_d;
  logic            flag_32hz_event_q;
  logic            flag_8hz_event_q;
  logic            flag_2hz_event_q;
  logic            flag_1hz_event_q;
  tick_events_type flags;
  tick_events_type flags_d;
  tick_events_type flag_clr;
  tick_events_type events;
  logic            irq_q;
  logic            irq_d;
  logic            setup;
  logic            access;
  logic            wr;
  logic            rd_setup;
  logic            sel_control;
  logic            sel_count;
  logic            sel_mask;
  logic            sel_flags;
  logic            mapped;
  logic            wr_control;
  logic            wr_mask;
  logic            wr_flags;
  logic            clear_req;
  logic [7:0]      rd_byte;
  logic [31:0]     prdata_q;
  logic [31:0]     prdata_d;

  ////////////////////////////////////////////////////////////////////
  // address compare shared by every register select
  function automatic logic hit(
    input logic [31:0] a,
    input logic [31:0] r
  );
    hit = (a == r);
  endfunction : hit

  // true when a step carries through every counter bit up to top
  function automatic logic wraps(
    input logic [7:0] cnt,
    input int         top
  );
    logic all_ones;
    all_ones = 1'b1;
    for (int i = 0; i < $bits(cnt); i++) begin
      if (i <= top) begin
        all_ones = all_ones & cnt[i];
      end
    end
    wraps = all_ones;
  endfunction : wraps

  // one flag bit; a new event wins over a write-one clear
  function automatic logic flag_next(
    input logic cur,
    input logic set,
    input logic clr
  );
    flag_next = set | (cur & ~clr);
  endfunction : flag_next

  ////////////////////////////////////////////////////////////////////
  // apb decode; each register takes one aligned word
  assign setup    = I_PSEL & ~I_PENABLE;
  assign access   = I_PSEL & I_PENABLE;
  assign wr       = access & I_PWRITE;
  assign rd_setup = setup & ~I_PWRITE;

  assign sel_control = hit(I_PADDR, ADDR_CONTROL);
  assign sel_count   = hit(I_PADDR, ADDR_COUNT);
  assign sel_mask    = hit(I_PADDR, ADDR_MASK);
  assign sel_flags   = hit(I_PADDR, ADDR_FLAGS);
  assign mapped      = sel_control | sel_count | sel_mask | sel_flags;

  assign wr_control = wr & sel_control;
  assign wr_mask    = wr & sel_mask;
  assign wr_flags   = wr & sel_flags;

  // zero wait states; unmapped addresses answer with an error
  assign O_PREADY  = 1'b1;
  assign O_PSLVERR = access & ~mapped;

  ////////////////////////////////////////////////////////////////////
  // clear on one
  assign clear_req = wr_control & I_PWDATA[BIT_CLEAR];

  always_comb begin
    run_d = run_q;
    if (wr_control) begin
      run_d = I_PWDATA[BIT_RUN];
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      run_q <= 1'b0;
    end else begin
      run_q <= run_d;
    end
  end

  // prescaler freezes with the counter so a stop does not lose phase
  assign pre_last = (pre_q == 32'(P_STEP_CYCLES - 1));
  assign step     = run_q & pre_last;

  always_comb begin
    pre_d = pre_q;
    if (clear_req || step) begin
      pre_d = '0;
    end else if (run_q) begin
      pre_d = pre_q + 32'h00000001;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_d;
    end
  end

  always_comb begin
    count_d = count_q;
    if (clear_req) begin
      count_d = RESET_BYTE;
    end else if (step) begin
      count_d = count_q + 8'h01;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      count_q <= RESET_BYTE;
    end else begin
      count_q <= count_d;
    end
  end

  // an event is the falling edge of its counter bit
  always_comb begin
    events.ev32 = step & wraps(count_q, CNT_EV32);
    events.ev8  = step & wraps(count_q, CNT_EV8);
    events.ev2  = step & wraps(count_q, CNT_EV2);
    events.ev1  = step & wraps(count_q, CNT_EV1);
  end

  ////////////////////////////////////////////////////////////////////
  // enable register
  always_comb begin
    mask_d = mask_q;
    if (wr_mask) begin
      mask_d = I_PWDATA[BIT_EV32:BIT_EV1];
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      mask_q <= RESET_NIB;
    end else begin
      mask_q <= mask_d;
    end
  end

  // write-one clear applies only to a flag register write
  always_comb begin
    flag_clr = RESET_NIB;
    if (wr_flags) begin
      flag_clr = I_PWDATA[BIT_EV32:BIT_EV1];
    end
  end

  always_comb begin
    flags_d.ev32 = flag_next(flags.ev32, events.ev32, flag_clr.ev32);
    flags_d.ev8  = flag_next(flags.ev8, events.ev8, flag_clr.ev8);
    flags_d.ev2  = flag_next(flags.ev2, events.ev2, flag_clr.ev2);
    flags_d.ev1  = flag_next(flags.ev1, events.ev1, flag_clr.ev1);
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      flag_32hz_event_q <= 1'b0;
    end else begin
      flag_32hz_event_q <= flags_d.ev32;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      flag_8hz_event_q <= 1'b0;
    end else begin
      flag_8hz_event_q <= flags_d.ev8;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      flag_2hz_event_q <= 1'b0;
    end else begin
      flag_2hz_event_q <= flags_d.ev2;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      flag_1hz_event_q <= 1'b0;
    end else begin
      flag_1hz_event_q <= flags_d.ev1;
    end
  end

  assign flags = {flag_32hz_event_q, flag_8hz_event_q,
                  flag_2hz_event_q, flag_1hz_event_q};

  assign irq_d = |(flags & mask_q);

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  // registered so the request never glitches
  assign O_IRQ = irq_q;

  ////////////////////////////////////////////////////////////////////
  // clear bit is write-only and reads zero
  always_comb begin
    rd_byte = RESET_BYTE;
    if (sel_control) begin
      rd_byte[BIT_RUN] = run_q;
    end else if (sel_count) begin
      rd_byte = count_q;
    end else if (sel_mask) begin
      rd_byte[BIT_EV32:BIT_EV1] = mask_q;
    end else if (sel_flags) begin
      rd_byte[BIT_EV32:BIT_EV1] = flags;
    end
  end

  // read data is captured in setup and stands through access;
  // a flag that sets during the access shows on the next read
  always_comb begin
    prdata_d = prdata_q;
    if (rd_setup) begin
      prdata_d = 32'(rd_byte);
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      prdata_q <= '0;
    end else begin
      prdata_q <= prdata_d;
    end
  end

  assign O_PRDATA = prdata_q;

endmodule : periodic_tick_timer

// ===== design/tick_timer_pkg.sv
// constants and types for the periodic tick timer
// assumes a 20 MHz system clock and a 32-bit apb register bus
package tick_timer_pkg;

  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_CONTROL = 16'h5000;
  localparam logic [15:0] IDX_COUNT   = 16'h5001;
  localparam logic [15:0] IDX_MASK    = 16'h5002;
  localparam logic [15:0] IDX_FLAGS   = 16'h5003;
  localparam logic [31:0] ADDR_CONTROL = {14'h0000, IDX_CONTROL, 2'h0};
  localparam logic [31:0] ADDR_COUNT   = {14'h0000, IDX_COUNT, 2'h0};
  localparam logic [31:0] ADDR_MASK    = {14'h0000, IDX_MASK, 2'h0};
  localparam logic [31:0] ADDR_FLAGS   = {14'h0000, IDX_FLAGS, 2'h0};

  // control field positions
  localparam int BIT_RUN   = 0;
  localparam int BIT_CLEAR = 4;

  // event bit positions in mask and flag registers
  localparam int BIT_EV32 = 3;
  localparam int BIT_EV8  = 2;
  localparam int BIT_EV2  = 1;
  localparam int BIT_EV1  = 0;

  // counter bit whose falling edge marks each event
  localparam int CNT_EV32 = 2;
  localparam int CNT_EV8  = 4;
  localparam int CNT_EV2  = 6;
  localparam int CNT_EV1  = 7;

  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [3:0] RESET_NIB  = 4'h0;

  // timing: counter steps at 256 Hz
  localparam int CLK_FREQ_HZ   = 20000000;
  localparam int COUNT_RATE_HZ = 256;
  localparam int STEP_CYCLES   = CLK_FREQ_HZ / COUNT_RATE_HZ;

  typedef struct packed {
    logic ev32;
    logic ev8;
    logic ev2;
    logic ev1;
  } tick_events_type;

endpackage : tick_timer_pkg

// ===== sim/tick_timer_monitor.sv
// port assertions for the tick timer
// assumes a zero-wait apb master
`timescale 1ns/10ps
module tick_timer_monitor
  import tick_timer_pkg::*;
(
  input wire logic        I_CLK,
  input wire logic        I_RST,
  input wire logic        I_PSEL,
  input wire logic        I_PENABLE,
  input wire logic        I_PWRITE,
  input wire logic [31:0] I_PADDR,
  input wire logic [31:0] O_PRDATA,
  input wire logic        O_IRQ
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  wire rd_acc = I_PSEL && I_PENABLE && !I_PWRITE;
  property p_hi; O_PRDATA[31:8] == 24'h000000; endproperty
  a_hi: assert property (p_hi) else $error("high bits");
  property p_ctl; rd_acc && I_PADDR == ADDR_CONTROL |-> O_PRDATA[7:1] == 7'h00;
  endproperty
  a_ctl: assert property (p_ctl) else $error("control bits");
  property p_msk; rd_acc && I_PADDR == ADDR_MASK |-> O_PRDATA[7:4] == 4'h0;
  endproperty
  a_msk: assert property (p_msk) else $error("mask bits");
  property p_flg; rd_acc && I_PADDR == ADDR_FLAGS |-> O_PRDATA[7:4] == 4'h0;
  endproperty
  a_flg: assert property (p_flg) else $error("flag bits");
  // nothing enabled right after reset, so no request
  property p_irq; $fell(I_RST) |-> !O_IRQ [*2]; endproperty
  a_irq: assert property (p_irq) else $error("irq after reset");
endmodule : tick_timer_monitor
bind periodic_tick_timer tick_timer_monitor u_mon (.I_CLK(I_CLK),
  .I_RST(I_RST), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
  .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .O_PRDATA(O_PRDATA),
  .O_IRQ(O_IRQ));

// ===== sim/testbench.sv
// self-checking bench for the tick timer
// assumes a four-cycle counter step
`timescale 1ns/10ps
module testbench
  import tick_timer_pkg::*;
;
  logic        clk = 0, rst = 1, sel = 0, en = 0, wr = 0, se = 0;
  logic [31:0] adr = 0, wd = 0, rd, a, b;
  logic        rdy, err, irq;
  logic [31:0] rdat;
  int          error_cnt = 0, n_checks = 0, seed = 20591, k;
  localparam int step_cycles = 4;
  periodic_tick_timer #(.P_STEP_CYCLES(step_cycles)) dut (.I_CLK(clk),
    .I_RST(rst), .I_PSEL(sel), .I_PENABLE(en), .I_PWRITE(wr),
    .I_PADDR(adr), .I_PWDATA(wd), .O_PREADY(rdy), .O_PSLVERR(err),
    .O_PRDATA(rdat), .O_IRQ(irq));
  initial forever #25 clk = ~clk;
  function automatic logic [31:0] msk(logic [31:0] v);
    return v & 32'h0000000F;
  endfunction : msk
  task automatic chk(input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [31:0] ad, d);
    @(posedge clk);
    sel <= 1;
    wr <= w;
    adr <= ad;
    wd <= d;
    @(posedge clk);
    en <= 1;
    do @(posedge clk); while (rdy !== 1'b1);
    rd = rdat;
    se = err;
    sel <= 0;
    en <= 0;
  endtask : xfer
  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop
  initial begin
    #(3000 * 50);
    error_cnt++;
    report_and_stop;
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 0;
    for (int i = 0; i < 4; i++) begin
      xfer(0, ADDR_CONTROL + 4 * i, 0);
      chk(rd, 32'h0);
    end
    $display("reset test done");
    xfer(1, ADDR_CONTROL, 32'h11);
    repeat (1100) @(posedge clk);
    // two reads whose setup edges lie step_cycles * k apart see k steps
    k = 1 + ($random(seed) & 7);
    xfer(0, ADDR_COUNT, 0);
    a = rd;
    repeat (step_cycles * k - 3) @(posedge clk);
    xfer(0, ADDR_COUNT, 0);
    chk((rd - a) & 32'hFF, k);
    xfer(0, ADDR_CONTROL, 0);
    chk(rd, 32'h1);
    xfer(1, ADDR_CONTROL, 32'h0);
    xfer(0, ADDR_COUNT, 0);
    a = rd;
    xfer(1, ADDR_COUNT, $random(seed));
    repeat (20) @(posedge clk);
    xfer(0, ADDR_COUNT, 0);
    chk(rd, a);
    $display("count test done");
    xfer(0, ADDR_FLAGS, 0);
    chk(rd, 32'hF);
    chk(irq, 0);
    b = $random(seed);
    xfer(1, ADDR_MASK, b);
    xfer(0, ADDR_MASK, 0);
    chk(rd, msk(b));
    xfer(1, ADDR_MASK, 32'hF);
    xfer(1, ADDR_FLAGS, 32'h0);
    xfer(0, ADDR_FLAGS, 0);
    chk(rd, 32'hF);
    chk(irq, 1);
    xfer(1, ADDR_FLAGS, 32'h5);
    xfer(0, ADDR_FLAGS, 0);
    chk(rd, 32'hA);
    xfer(1, ADDR_FLAGS, 32'hA);
    repeat (2) @(posedge clk);
    chk(irq, 0);
    xfer(1, ADDR_CONTROL, 32'h10);
    xfer(0, ADDR_COUNT, 0);
    chk(rd, 32'h0);
    xfer(0, 32'h0, 0);
    chk(se, 1);
    $display("flag test done");
    report_and_stop;
  end
endmodule : testbench
